/* hdl/fped_decoder.sv */
// flash page expansion decoder with page index port
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
// Function
// - decode 16K user window 8000-BFFF from the indexed flash page
// - index bits 2:1 pick array, bit 0 picks half
// - page six fixed at 4000-7FFF, page seven at C000-FFFF
// - flash register window F4-F7, array chosen by index bits 2:1
// - special mode plus test bit gives 32K window 8000-FFFF
// - test window never presented outside special mode
// - three index pins and chip select when emulating; bit 3 always I/O
// - data writes do not change pins driving emulated index
// - data and direction unmapped in peripheral/expanded with emulation on
// - chip select low for program window access to flash or external
// - chip select in E high phase, stretched for external access
// - chip select inactive unless emulation enabled
// - index pins drive the page index register contents
// - direction 0 input, 1 output, reset to 0
// - input pins selectable plain or pulled up
// - data register read and write anytime where mapped
// - stretch code n adds n-1 E clocks (0-2), only external in expanded mode
module fped_decoder (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // register port
  input wire logic [15:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [7:0] reg_rdata_o,
  // system state
  input wire logic [1:0] op_mode_i,
  input wire logic e_clock_high_i,
  // cpu address bus
  input wire logic [15:0] cpu_addr_i,
  input wire logic cpu_valid_i,
  input wire logic ext_present_i,
  // decode results
  output logic user_window_o,
  output logic test_window_o,
  output logic fixed_window_o,
  output logic flash_reg_window_o,
  output logic [1:0] flash_array_o,
  output logic [14:0] flash_offset_o,
  output logic [1:0] flash_reg_offset_o,
  output logic ext_access_o,
  output logic stretch_busy_o,
  // page port pins
  input wire logic [7:0] port_pin_i,
  output logic [7:0] port_pin_o,
  output logic [7:0] port_pin_oe_o,
  output logic [7:0] port_pullup_o
);
  logic [2:0] program_page_index;
  logic flash_test_window_enable;
  logic page_emulation_enable;
  logic [1:0] external_stretch;
  logic pullup_enable;
  logic [7:0] page_port_data;
  logic [7:0] page_port_direction;
  fped_pkg::fped_mode_t mode;
  fped_pkg::fped_cs_state_t cs_state;
  fped_pkg::fped_cs_state_t next_cs_state;
  logic [1:0] stretch_count;
  logic special;
  logic expanded_like;
  logic test_active;
  logic in_user;
  logic in_fixed6;
  logic in_fixed7;
  logic in_test;
  logic in_freg;
  logic program_hit;
  logic ext_hit;
  logic port_mapped;
  logic hit_data;
  logic hit_direction;
  logic emulated_chip_select;
  logic [2:0] page_index_out;

  function automatic logic in_range(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  assign mode = fped_pkg::fped_mode_t'(op_mode_i);
  assign special = (mode == fped_pkg::FPED_SPECIAL);
  assign expanded_like = (mode == fped_pkg::FPED_EXPANDED) ||
                         (mode == fped_pkg::FPED_PERIPHERAL);
  // test bit only counts in special mode
  assign test_active = special && flash_test_window_enable;

  // address decode
  assign in_test = test_active &&
                   in_range(cpu_addr_i, fped_pkg::TEST_WIN_LO,
                            fped_pkg::TEST_WIN_HI);
  assign in_user = !test_active &&
                   in_range(cpu_addr_i, fped_pkg::USER_WIN_LO,
                            fped_pkg::USER_WIN_HI);
  assign in_fixed6 = in_range(cpu_addr_i, fped_pkg::FIXED6_LO,
                              fped_pkg::FIXED6_HI);
  assign in_fixed7 = !test_active &&
                     in_range(cpu_addr_i, fped_pkg::FIXED7_LO,
                              fped_pkg::FIXED7_HI);
  assign in_freg = in_range(cpu_addr_i, fped_pkg::FREG_WIN_LO,
                            fped_pkg::FREG_WIN_HI);
  assign program_hit = in_user || in_test;
  // external only in expanded-style modes, never single chip
  assign ext_hit = cpu_valid_i && ext_present_i && expanded_like;

  // registered decode results
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      user_window_o <= 1'b0;
      test_window_o <= 1'b0;
      fixed_window_o <= 1'b0;
      flash_reg_window_o <= 1'b0;
      flash_array_o <= 2'h0;
      flash_offset_o <= 15'h0000;
      flash_reg_offset_o <= 2'h0;
      ext_access_o <= 1'b0;
    end else begin
      user_window_o <= cpu_valid_i && in_user;
      test_window_o <= cpu_valid_i && in_test;
      fixed_window_o <= cpu_valid_i && (in_fixed6 || in_fixed7);
      flash_reg_window_o <= cpu_valid_i && in_freg;
      flash_reg_offset_o <= cpu_addr_i[1:0];
      ext_access_o <= ext_hit;
      if (in_test) begin
        // index bits 2:1 act as upper address bits
        flash_array_o <= program_page_index[2:1];
        flash_offset_o <= cpu_addr_i[14:0];
      end else if (in_user) begin
        flash_array_o <= program_page_index[2:1];
        flash_offset_o <= {program_page_index[0], cpu_addr_i[13:0]};
      end else if (in_fixed6) begin
        flash_array_o <= fped_pkg::PAGE_SIX[2:1];
        flash_offset_o <= {fped_pkg::PAGE_SIX[0], cpu_addr_i[13:0]};
      end else if (in_fixed7) begin
        flash_array_o <= fped_pkg::PAGE_SEVEN[2:1];
        flash_offset_o <= {fped_pkg::PAGE_SEVEN[0], cpu_addr_i[13:0]};
      end else if (in_freg) begin
        flash_array_o <= program_page_index[2:1];
        flash_offset_o <= 15'h0000;
      end else begin
        flash_array_o <= 2'h0;
        flash_offset_o <= 15'h0000;
      end
    end
  end

  // register access
  assign port_mapped = !(expanded_like && page_emulation_enable);
  assign hit_data = port_mapped &&
                    (reg_addr_i == fped_pkg::PAGE_PORT_DATA_OFS);
  assign hit_direction = port_mapped &&
                         (reg_addr_i == fped_pkg::PAGE_PORT_DIRECTION_OFS);

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      program_page_index <= fped_pkg::PAGE_INDEX_RESET;
    end else if (reg_write_i &&
                 reg_addr_i == fped_pkg::PROGRAM_PAGE_INDEX_OFS) begin
      program_page_index <= reg_wdata_i[2:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      flash_test_window_enable <= 1'b0;
      page_emulation_enable <= 1'b0;
      external_stretch <= 2'h0;
      pullup_enable <= 1'b0;
    end else if (reg_write_i && reg_addr_i == fped_pkg::MAP_CONTROL_OFS) begin
      flash_test_window_enable <= reg_wdata_i[fped_pkg::CTL_TEST_WIN_BIT];
      page_emulation_enable <= reg_wdata_i[fped_pkg::CTL_EMU_BIT];
      external_stretch <= reg_wdata_i[fped_pkg::CTL_STRETCH_LSB +: 2];
      pullup_enable <= reg_wdata_i[fped_pkg::CTL_PULLUP_BIT];
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      page_port_data <= 8'h00;
    end else if (reg_write_i && hit_data) begin
      page_port_data <= reg_wdata_i & fped_pkg::PORT_IMPL_MASK;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      page_port_direction <= fped_pkg::DIRECTION_RESET;
    end else if (reg_write_i && hit_direction) begin
      page_port_direction <= reg_wdata_i & fped_pkg::PORT_IMPL_MASK;
    end
  end

  // read data, one cycle after the strobe, zero otherwise
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (!reg_read_i) begin
      reg_rdata_o <= 8'h00;
    end else if (hit_data) begin
      // output pins read the driven port_pin_o, input pins read the pin
      reg_rdata_o <= ((port_pin_o & port_pin_oe_o) |
                      (port_pin_i & ~port_pin_oe_o)) &
                     fped_pkg::PORT_IMPL_MASK;
    end else if (hit_direction) begin
      reg_rdata_o <= page_port_direction;
    end else if (reg_addr_i == fped_pkg::PROGRAM_PAGE_INDEX_OFS) begin
      reg_rdata_o <= {5'h00, program_page_index};
    end else if (reg_addr_i == fped_pkg::MAP_CONTROL_OFS) begin
      reg_rdata_o <= {3'h0, pullup_enable, external_stretch,
                      page_emulation_enable, test_active};
    end else if (reg_addr_i == fped_pkg::DECODE_STATUS_OFS) begin
      reg_rdata_o <= {2'h0, cs_state, stretch_count,
                      emulated_chip_select, test_active};
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // chip select: E high phase, plus stretch E clocks for external in expanded mode
  always_comb begin
    next_cs_state = cs_state;
    unique case (cs_state)
      fped_pkg::FPED_CS_IDLE: begin
        if (page_emulation_enable && cpu_valid_i && program_hit &&
            e_clock_high_i) begin
          next_cs_state = fped_pkg::FPED_CS_HIGH;
        end
      end
      fped_pkg::FPED_CS_HIGH: begin
        if (!e_clock_high_i) begin
          // only expanded mode stretches; peripheral external access gets no stretch
          if (ext_hit && mode == fped_pkg::FPED_EXPANDED &&
              external_stretch != 2'h0) begin
            next_cs_state = fped_pkg::FPED_CS_STRETCH;
          end else begin
            next_cs_state = fped_pkg::FPED_CS_IDLE;
          end
        end
      end
      fped_pkg::FPED_CS_STRETCH: begin
        if (!e_clock_high_i && stretch_count == 2'h0) begin
          next_cs_state = fped_pkg::FPED_CS_IDLE;
        end
      end
      default: next_cs_state = fped_pkg::FPED_CS_IDLE;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cs_state <= fped_pkg::FPED_CS_IDLE;
    end else if (!page_emulation_enable) begin
      cs_state <= fped_pkg::FPED_CS_IDLE;
    end else begin
      cs_state <= next_cs_state;
    end
  end

  // counts remaining stretched E clocks by falling E edges seen low
  logic e_high_q;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      e_high_q <= 1'b0;
    end else begin
      e_high_q <= e_clock_high_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      stretch_count <= 2'h0;
    end else if (cs_state == fped_pkg::FPED_CS_HIGH && !e_clock_high_i) begin
      stretch_count <= external_stretch - 2'h1;
    end else if (cs_state == fped_pkg::FPED_CS_STRETCH &&
                 e_high_q && !e_clock_high_i && stretch_count != 2'h0) begin
      stretch_count <= stretch_count - 2'h1;
    end
  end

  assign emulated_chip_select = (cs_state != fped_pkg::FPED_CS_IDLE);
  assign stretch_busy_o = (cs_state == fped_pkg::FPED_CS_STRETCH);
  assign page_index_out = program_page_index;

  // pin drive: emulation overrides data latch on index and select pins
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      port_pin_o <= 8'h00;
      port_pin_oe_o <= 8'h00;
      port_pullup_o <= 8'h00;
    end else begin
      port_pin_o <= page_port_data;
      port_pin_oe_o <= page_port_direction;
      if (page_emulation_enable) begin
        port_pin_o[2:0] <= page_index_out;
        port_pin_o[fped_pkg::PORT_CS_BIT] <= !emulated_chip_select;
        port_pin_oe_o[2:0] <= 3'h7;
        port_pin_oe_o[fped_pkg::PORT_CS_BIT] <= 1'b1;
      end
      // bit 3 stays general I/O, taken from the latch above
      port_pullup_o <= pullup_enable ?
                       (~page_port_direction & fped_pkg::PORT_IMPL_MASK) :
                       8'h00;
    end
  end
endmodule

/* hdl/fped_pkg.sv */
// constants for the flash page expansion decoder
package fped_pkg;
  // register offsets on the plain register port
  localparam logic [15:0] PAGE_PORT_DATA_OFS = 16'h00fc;
  localparam logic [15:0] PAGE_PORT_DIRECTION_OFS = 16'h00fd;
  localparam logic [15:0] PROGRAM_PAGE_INDEX_OFS = 16'h0030;
  localparam logic [15:0] MAP_CONTROL_OFS = 16'h0031;
  localparam logic [15:0] DECODE_STATUS_OFS = 16'h0032;
  // port bit positions
  localparam int PORT_CS_BIT = 7;
  localparam int PORT_GPIO_BIT = 3;
  localparam logic [7:0] PORT_IMPL_MASK = 8'h8f;
  localparam logic [7:0] DIRECTION_RESET = 8'h00;
  localparam logic [2:0] PAGE_INDEX_RESET = 3'h0;
  // map control fields
  localparam int CTL_TEST_WIN_BIT = 0;
  localparam int CTL_EMU_BIT = 1;
  localparam int CTL_STRETCH_LSB = 2;
  localparam int CTL_PULLUP_BIT = 4;
  // address windows
  localparam logic [15:0] USER_WIN_LO = 16'h8000;
  localparam logic [15:0] USER_WIN_HI = 16'hbfff;
  localparam logic [15:0] FIXED6_LO = 16'h4000;
  localparam logic [15:0] FIXED6_HI = 16'h7fff;
  localparam logic [15:0] FIXED7_LO = 16'hc000;
  localparam logic [15:0] FIXED7_HI = 16'hffff;
  localparam logic [15:0] TEST_WIN_LO = 16'h8000;
  localparam logic [15:0] TEST_WIN_HI = 16'hffff;
  localparam logic [15:0] FREG_WIN_LO = 16'h00f4;
  localparam logic [15:0] FREG_WIN_HI = 16'h00f7;
  localparam logic [2:0] PAGE_SIX = 3'h6;
  localparam logic [2:0] PAGE_SEVEN = 3'h7;
  // operating modes
  typedef enum logic [1:0] {
    FPED_SINGLE_CHIP = 2'b00,
    FPED_EXPANDED = 2'b01,
    FPED_PERIPHERAL = 2'b10,
    FPED_SPECIAL = 2'b11
  } fped_mode_t;
  typedef enum logic [1:0] {
    FPED_CS_IDLE = 2'b00,
    FPED_CS_HIGH = 2'b01,
    FPED_CS_STRETCH = 2'b10
  } fped_cs_state_t;
endpackage

/* tb/fped_monitor.sv */
// port checker for the flash page expansion decoder
`timescale 1ns/1ps
module fped_monitor (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // watched ports
  input wire logic reg_read_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [1:0] op_mode_i,
  input wire logic [15:0] cpu_addr_i,
  input wire logic cpu_valid_i,
  input wire logic ext_present_i,
  input wire logic user_window_o,
  input wire logic test_window_o,
  input wire logic fixed_window_o,
  input wire logic flash_reg_window_o,
  input wire logic [1:0] flash_reg_offset_o,
  input wire logic ext_access_o,
  input wire logic stretch_busy_o,
  input wire logic [7:0] port_pin_o,
  input wire logic [7:0] port_pin_oe_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  rdata_idle_a: assert property (!$past(reg_read_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside its slot");
  user_win_a: assert property (user_window_o |->
    $past(cpu_addr_i) inside {[16'h8000:16'hbfff]}) else $error("user window");
  test_special_a: assert property (test_window_o |-> $past(cpu_addr_i[15]) &&
    $past(op_mode_i) == fped_pkg::FPED_SPECIAL) else $error("test window");
  fixed_win_a: assert property (fixed_window_o |->
    $past(cpu_addr_i[14])) else $error("fixed alias");
  freg_win_a: assert property (flash_reg_window_o |->
    $past(cpu_addr_i[15:2]) == 14'h003d &&
    flash_reg_offset_o == $past(cpu_addr_i[1:0])) else $error("reg window");
  win_excl_a: assert property (!(user_window_o && test_window_o))
    else $error("both windows");
  unimpl_bits_a: assert property (((port_pin_o | port_pin_oe_o) & 8'h70)
    == 8'h00) else $error("bits 6 to 4 active");
  ext_cause_a: assert property (ext_access_o |->
    $past(ext_present_i && cpu_valid_i)) else $error("external access");
  stretch_mode_a: assert property (stretch_busy_o |->
    op_mode_i inside {fped_pkg::FPED_EXPANDED, fped_pkg::FPED_SPECIAL})
    else $error("stretch in wrong mode");
  reset_oe_a: assert property (disable iff (1'b0) rst_i |=>
    port_pin_oe_o == 8'h00) else $error("pins driven in reset");
  cover property (test_window_o);
  cover property (stretch_busy_o);
  cover property (flash_reg_window_o);
endmodule
bind fped_decoder fped_monitor i_mon (.clock_i(clock_i), .rst_i(rst_i),
  .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .op_mode_i(op_mode_i),
  .cpu_addr_i(cpu_addr_i), .cpu_valid_i(cpu_valid_i),
  .ext_present_i(ext_present_i), .user_window_o(user_window_o),
  .test_window_o(test_window_o), .fixed_window_o(fixed_window_o),
  .flash_reg_window_o(flash_reg_window_o),
  .flash_reg_offset_o(flash_reg_offset_o), .ext_access_o(ext_access_o),
  .stretch_busy_o(stretch_busy_o), .port_pin_o(port_pin_o),
  .port_pin_oe_o(port_pin_oe_o));

/* tb/fped_pad_model.sv */
// pad model resolving the page port pin levels
`timescale 1ns/1ps
module fped_pad_model (
  // pad side of the design
  input wire logic clock_i,
  input wire logic [7:0] pin_out_i,
  input wire logic [7:0] pin_oe_i,
  input wire logic [7:0] pullup_i,
  // resolved levels
  output logic [7:0] level_o
);
  logic [7:0] last = 8'h00;
  // a floating pin must not keep a stale level, so it flips
  always_ff @(posedge clock_i) last <= level_o;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe_i[i]) level_o[i] = pin_out_i[i];
      else if (pullup_i[i]) level_o[i] = 1'b1;
      else level_o[i] = ~last[i];
    end
  end
endmodule

/* tb/fped_decoder_tb.sv */
// self-checking bench for the flash page expansion decoder
`timescale 1ns/1ps
module fped_decoder_tb;
  localparam logic [15:0] DAT = fped_pkg::PAGE_PORT_DATA_OFS;
  localparam logic [15:0] DIR = fped_pkg::PAGE_PORT_DIRECTION_OFS;
  localparam logic [15:0] PPI = fped_pkg::PROGRAM_PAGE_INDEX_OFS;
  localparam logic [15:0] CTL = fped_pkg::MAP_CONTROL_OFS;
  logic clock_i = 0, rst_i = 1, reg_write_i = 0, reg_read_i = 0;
  logic [15:0] reg_addr_i = 0, cpu_addr_i = 0;
  logic [7:0] reg_wdata_i = 0, reg_rdata_o, port_pin_i;
  logic [7:0] port_pin_o, port_pin_oe_o, port_pullup_o;
  logic [1:0] op_mode_i = 0, flash_array_o, flash_reg_offset_o;
  logic e_clock_high_i = 0, cpu_valid_i = 0, ext_present_i = 0;
  logic user_window_o, test_window_o, fixed_window_o, flash_reg_window_o;
  logic ext_access_o, stretch_busy_o;
  logic [14:0] flash_offset_o;
  int fail_count = 0, checked = 0, busy;
  always #2.5 clock_i = ~clock_i;
  fped_decoder i_dut (.clock_i(clock_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o), .op_mode_i(op_mode_i),
    .e_clock_high_i(e_clock_high_i), .cpu_addr_i(cpu_addr_i),
    .cpu_valid_i(cpu_valid_i), .ext_present_i(ext_present_i),
    .user_window_o(user_window_o), .test_window_o(test_window_o),
    .fixed_window_o(fixed_window_o), .flash_reg_window_o(flash_reg_window_o),
    .flash_array_o(flash_array_o), .flash_offset_o(flash_offset_o),
    .flash_reg_offset_o(flash_reg_offset_o), .ext_access_o(ext_access_o),
    .stretch_busy_o(stretch_busy_o), .port_pin_i(port_pin_i),
    .port_pin_o(port_pin_o), .port_pin_oe_o(port_pin_oe_o),
    .port_pullup_o(port_pullup_o));
  fped_pad_model i_pad (.clock_i(clock_i), .pin_out_i(port_pin_o),
    .pin_oe_i(port_pin_oe_o), .pullup_i(port_pullup_o), .level_o(port_pin_i));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge clock_i);
    reg_write_i <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge clock_i);
    reg_read_i <= 1'b0;
    #1 chk("rdata", e, reg_rdata_o);
  endtask
  task automatic probe(input logic [15:0] a);
    @(posedge clock_i);
    cpu_addr_i <= a;
    cpu_valid_i <= 1'b1;
    @(posedge clock_i);
    #1;
  endtask
  task automatic mode(input logic [1:0] m);
    @(posedge clock_i);
    op_mode_i <= m;
  endtask
  // toggles the E phase every two cycles and counts stretch cycles
  task automatic e_run;
    busy = 0;
    for (int k = 0; k < 24; k++) begin
      @(posedge clock_i);
      e_clock_high_i <= k[1];
      #1 if (stretch_busy_o === 1'b1) busy++;
    end
  endtask
  initial begin
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(DIR, 8'h00);
    chk("oe", 16'h0000, port_pin_oe_o);
    wr(DIR, 8'hff);
    rd(DIR, 8'h8f);
    $display("test reset and masks done");
    for (int p = 0; p < 8; p++) begin
      wr(PPI, 8'(p));
      probe(16'h8123);
      chk("user", 16'h0001, user_window_o);
      chk("array", p[2:1], flash_array_o);
      chk("offset", {p[0], 14'h0123}, flash_offset_o);
      probe(16'h00f5);
      chk("freg", 16'h0001, flash_reg_window_o);
      chk("freg array", p[2:1], flash_array_o);
      chk("freg offset", 16'h0001, flash_reg_offset_o);
    end
    wr(PPI, 8'h00);
    probe(16'hc010);
    chk("fixed", 16'h0001, fixed_window_o);
    chk("fixed array", 16'h0003, flash_array_o);
    chk("fixed offset", 16'h4010, flash_offset_o);
    $display("test paging done");
    mode(fped_pkg::FPED_SPECIAL);
    wr(CTL, 8'h01);
    wr(PPI, 8'h04);
    probe(16'hc123);
    chk("test win", 16'h0001, test_window_o);
    chk("test array", 16'h0002, flash_array_o);
    chk("test offset", 16'h4123, flash_offset_o);
    mode(fped_pkg::FPED_EXPANDED);
    rd(CTL, 8'h00);
    probe(16'hc123);
    chk("test off", 16'h0000, test_window_o);
    $display("test window done");
    mode(fped_pkg::FPED_SINGLE_CHIP);
    wr(CTL, 8'h10);
    wr(DIR, 8'h0f);
    wr(DAT, 8'h05);
    rd(DAT, 8'h85);
    chk("oe", 16'h000f, port_pin_oe_o);
    chk("pull", 16'h0080, port_pullup_o);
    wr(DIR, 8'h80);
    wr(DAT, 8'h80);
    e_clock_high_i <= 1'b1;
    probe(16'h8123);
    repeat (3) @(posedge clock_i);
    #1 chk("cs off", 16'h0001, port_pin_o[7]);
    $display("test gpio done");
    wr(DIR, 8'h00);
    wr(PPI, 8'h05);
    wr(CTL, 8'h12);
    wr(DAT, 8'h00);
    repeat (2) @(posedge clock_i);
    #1 chk("pix", 16'h0005, port_pin_o & 8'h07);
    chk("pix oe", 16'h0007, port_pin_oe_o & 8'h07);
    for (int k = 0; k < 9 && port_pin_o[7] !== 1'b0; k++) begin
      @(posedge clock_i);
      #1 if (k == 8) begin
        chk("cs on", 16'h0000, port_pin_o[7]);
        tally_and_finish();
      end
    end
    chk("cs on", 16'h0000, port_pin_o[7]);
    mode(fped_pkg::FPED_EXPANDED);
    wr(DIR, 8'hff);
    rd(DIR, 8'h00);
    wr(CTL, 8'h0a);
    ext_present_i <= 1'b1;
    e_run();
    chk("stretch", 16'h0001, busy > 0);
    // emulation off parks the select idle; e may be frozen high mid-stretch
    wr(CTL, 8'h00);
    wr(CTL, 8'h02);
    e_run();
    chk("no stretch", 16'h0000, busy);
    $display("test emulation done");
    tally_and_finish();
  end
endmodule
